// ==== rtl/lanes_map.svh ====
`ifndef LANES_MAP_SVH
`define LANES_MAP_SVH

// ****************************************
// Lane geometry
// ****************************************
`define LANE_WIDTH 64
`define GROUP_WIDTH 16
`define GROUP_COUNT 4
`define BEATS_PER_PERIOD 4

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 40
`define BUS_CLK_PERIOD_NS 320
`define PHASES_PER_PERIOD ((`BUS_CLK_PERIOD_NS) / (`CLK_PERIOD_NS))
`define LAST_PHASE 3'h7

// ****************************************
// Inversion and reset values
// ****************************************
`define INV_THRESHOLD 5'h08
`define PIN_IDLE_HIGH 1'b1
`define WORD_RESET 64'h0000_0000_0000_0000

`endif

// ==== rtl/lanes_pkg.sv ====
package lanes_pkg;

    // Sampled or driven pin levels, all electrical
    typedef struct packed {
        logic [63:0] data;
        logic [3:0] strobe_p;
        logic [3:0] strobe_n;
        logic [3:0] inv;
        logic valid;
    } pin_bundle_type;

    // Four logical words of one bus clock period, word 0 first
    typedef struct packed {
        logic [3:0][63:0] word;
    } burst_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_WAIT = 2'b01,
        TX_DRIVE = 2'b10
    } tx_state_type;

endpackage

// ==== rtl/group_encoder.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lanes_map.svh"

module group_encoder (
    // Logical word of one group
    input wire logic [15:0] word,
    // Electrical levels to drive
    output logic [15:0] pins,
    output logic inv_pin
);

    function automatic logic [4:0] ones(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction

    logic invert;

    // A logical one is an electrical low, so ones count the low lines
    assign invert = ones(word) > `INV_THRESHOLD;
    assign pins = invert ? word : ~word;
    assign inv_pin = ~invert;

endmodule

`default_nettype wire

// ==== rtl/quad_pumped_data_lanes.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "lanes_map.svh"

// Overview of operation
// - All agents share one 64-line data path; this block drives and receives all 64.
// - Driver asserts data_valid_indicator for its transfer; receiver accepts only while asserted.
// - Driver presents four successive words within each bus clock period.
// - Receiver captures on falling edges of positive and negative strobes of the group.
// - Four 16-line groups, each timed by its own strobe pair, index by bits.
// - Each 16-line group has one inversion flag with matching index.
// - With a group's inversion flag active, its lines are read active high.
module quad_pumped_data_lanes (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus clock, sampled as a level
    input wire logic bus_clk,
    // Data lines, active low
    input wire logic [63:0] data_lines_n_in,
    output logic [63:0] data_lines_n_out,
    output logic data_lines_n_oe,
    // Strobes, per group
    input wire logic [3:0] data_strobe_positive_n_in,
    output logic [3:0] data_strobe_positive_n_out,
    output logic data_strobe_positive_n_oe,
    input wire logic [3:0] data_strobe_negative_n_in,
    output logic [3:0] data_strobe_negative_n_out,
    output logic data_strobe_negative_n_oe,
    // Inversion flags, per group
    input wire logic [3:0] group_inversion_flag_n_in,
    output logic [3:0] group_inversion_flag_n_out,
    output logic group_inversion_flag_n_oe,
    // Data valid
    input wire logic data_valid_indicator_n_in,
    output logic data_valid_indicator_n_out,
    output logic data_valid_indicator_n_oe,
    // Transmit request
    input wire logic tx_req,
    input wire lanes_pkg::burst_type tx_burst,
    output logic tx_ready,
    // Receive stream
    output logic rx_valid,
    output logic [63:0] rx_data
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    lanes_pkg::pin_bundle_type pins_now;
    lanes_pkg::pin_bundle_type meta_reg, meta_next;
    lanes_pkg::pin_bundle_type samp_reg, samp_next;
    logic [3:0] strobe_p_old_reg, strobe_p_old_next;
    logic [3:0] strobe_n_old_reg, strobe_n_old_next;
    logic [2:0] bclk_sync_reg, bclk_sync_next;
    logic [1:0] echo_reg, echo_next;

    assign pins_now = '{data: data_lines_n_in, strobe_p: data_strobe_positive_n_in,
                        strobe_n: data_strobe_negative_n_in, inv: group_inversion_flag_n_in,
                        valid: data_valid_indicator_n_in};

    always_comb begin
        meta_next = pins_now;
        samp_next = meta_reg;
        strobe_p_old_next = samp_reg.strobe_p;
        strobe_n_old_next = samp_reg.strobe_n;
        bclk_sync_next = {bclk_sync_reg[1:0], bus_clk};
        // Our own drive returns through the pins two cycles late
        echo_next = {echo_reg[0], data_lines_n_oe};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '1;
            samp_reg <= '1;
            strobe_p_old_reg <= 4'hf;
            strobe_n_old_reg <= 4'hf;
            // Reset high so a bus clock already high at release is not taken as a rise
            bclk_sync_reg <= 3'h7;
            echo_reg <= 2'h0;
        end else begin
            meta_reg <= meta_next;
            samp_reg <= samp_next;
            strobe_p_old_reg <= strobe_p_old_next;
            strobe_n_old_reg <= strobe_n_old_next;
            bclk_sync_reg <= bclk_sync_next;
            echo_reg <= echo_next;
        end
    end

    logic bclk_rise;

    assign bclk_rise = bclk_sync_reg[1] & ~bclk_sync_reg[2];

    // ****************************************
    // Receive capture
    // ****************************************
    logic [3:0] pending_reg, pending_next;
    logic [3:0][15:0] held_reg, held_next;
    logic rx_valid_reg, rx_valid_next;
    logic [63:0] rx_data_reg, rx_data_next;
    logic [3:0] capture;
    logic [3:0][15:0] decoded;
    logic accept;

    // Pins are stable around the strobe edge, so the same sample serves both
    assign accept = ~samp_reg.valid & ~echo_reg[1] & ~data_lines_n_oe;

    always_comb begin
        for (int g = 0; g < `GROUP_COUNT; g++) begin
            capture[g] = accept & ((strobe_p_old_reg[g] & ~samp_reg.strobe_p[g]) |
                                   (strobe_n_old_reg[g] & ~samp_reg.strobe_n[g]));
            decoded[g] = samp_reg.inv[g] ? ~samp_reg.data[g*16 +: 16]
                                         : samp_reg.data[g*16 +: 16];
        end
    end

    always_comb begin
        pending_next = pending_reg;
        held_next = held_reg;
        rx_valid_next = 1'b0;
        rx_data_next = rx_data_reg;
        if (&pending_reg) begin
            rx_valid_next = 1'b1;
            rx_data_next = held_reg;
            pending_next = 4'h0;
        end
        // A capture in the emit cycle still counts
        for (int g = 0; g < `GROUP_COUNT; g++) begin
            if (capture[g]) begin
                pending_next[g] = 1'b1;
                held_next[g] = decoded[g];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending_reg <= 4'h0;
            held_reg <= `WORD_RESET;
            rx_valid_reg <= 1'b0;
            rx_data_reg <= `WORD_RESET;
        end else begin
            pending_reg <= pending_next;
            held_reg <= held_next;
            rx_valid_reg <= rx_valid_next;
            rx_data_reg <= rx_data_next;
        end
    end

    assign rx_valid = rx_valid_reg;
    assign rx_data = rx_data_reg;

    // ****************************************
    // Transmit sequencer
    // ****************************************
    lanes_pkg::tx_state_type state_reg, state_next;
    logic [2:0] phase_reg, phase_next;
    lanes_pkg::burst_type burst_reg, burst_next;

    assign tx_ready = (state_reg == lanes_pkg::TX_IDLE);

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        burst_next = burst_reg;
        unique case (state_reg)
            lanes_pkg::TX_IDLE: begin
                if (tx_req) begin
                    burst_next = tx_burst;
                    state_next = lanes_pkg::TX_WAIT;
                end
            end
            lanes_pkg::TX_WAIT: begin
                // Start aligned to a bus clock period
                if (bclk_rise) begin
                    phase_next = 3'h0;
                    state_next = lanes_pkg::TX_DRIVE;
                end
            end
            lanes_pkg::TX_DRIVE: begin
                phase_next = phase_reg + 3'h1;
                if (phase_reg == `LAST_PHASE) begin
                    phase_next = 3'h0;
                    state_next = lanes_pkg::TX_IDLE;
                end
            end
            default: begin
                state_next = lanes_pkg::TX_IDLE;
                phase_next = 3'h0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= lanes_pkg::TX_IDLE;
            phase_reg <= 3'h0;
            burst_reg <= '0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            burst_reg <= burst_next;
        end
    end

    // ****************************************
    // Pin drive
    // ****************************************
    logic [63:0] word_next;
    logic [63:0] enc_pins;
    logic [3:0] enc_inv;
    logic drive_next;
    lanes_pkg::pin_bundle_type out_reg, out_next;
    logic oe_reg;

    // Two clock phases per word, four words per period
    assign word_next = burst_reg.word[phase_next[2:1]];

    for (genvar g = 0; g < `GROUP_COUNT; g++) begin : enc
        group_encoder u_enc (
            .word(word_next[g*16 +: 16]),
            .pins(enc_pins[g*16 +: 16]),
            .inv_pin(enc_inv[g])
        );
    end

    assign drive_next = (state_next == lanes_pkg::TX_DRIVE);

    always_comb begin
        out_next = '1;
        if (drive_next) begin
            out_next.data = enc_pins;
            out_next.inv = enc_inv;
            out_next.valid = 1'b0;
            // Positive strobe falls mid words 0 and 2, negative mid words 1 and 3
            out_next.strobe_p = {4{~(phase_next[0] ^ phase_next[1])}};
            // Negative strobe stays high through word 0, else it would fall once too often
            out_next.strobe_n = {4{~((phase_next[1:0] == 2'h3) | (phase_next == 3'h4))}};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_reg <= '1;
            oe_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            oe_reg <= drive_next;
        end
    end

    assign data_lines_n_out = out_reg.data;
    assign data_lines_n_oe = oe_reg;
    assign data_strobe_positive_n_out = out_reg.strobe_p;
    assign data_strobe_positive_n_oe = oe_reg;
    assign data_strobe_negative_n_out = out_reg.strobe_n;
    assign data_strobe_negative_n_oe = oe_reg;
    assign group_inversion_flag_n_out = out_reg.inv;
    assign group_inversion_flag_n_oe = oe_reg;
    assign data_valid_indicator_n_out = out_reg.valid;
    assign data_valid_indicator_n_oe = oe_reg;

endmodule

`default_nettype wire

// ==== sim/lanes_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************
// Port checker
// ****************
module lanes_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Driven pins
    input wire logic [63:0] data_lines_n_out,
    input wire logic data_lines_n_oe,
    input wire logic [3:0] data_strobe_positive_n_out,
    input wire logic data_strobe_positive_n_oe,
    input wire logic [3:0] data_strobe_negative_n_out,
    input wire logic [3:0] group_inversion_flag_n_out,
    input wire logic data_valid_indicator_n_out,
    // User side
    input wire logic tx_ready,
    input wire logic rx_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_drive_span: assert property ($rose(data_lines_n_oe) |-> data_lines_n_oe [*8] ##1 !data_lines_n_oe)
        else $error("drive length wrong");
    chk_valid_drive: assert property (data_lines_n_oe == !data_valid_indicator_n_out)
        else $error("valid not tied to drive");
    chk_oe_same: assert property (data_strobe_positive_n_oe == data_lines_n_oe)
        else $error("enables differ");
    chk_strobe_pos: assert property ($rose(data_lines_n_oe) |-> data_strobe_positive_n_out == 4'hf ##1
        data_strobe_positive_n_out == 4'h0 ##1 data_strobe_positive_n_out == 4'h0 ##1 data_strobe_positive_n_out == 4'hf)
        else $error("positive strobe pattern wrong");
    chk_strobe_neg: assert property ($rose(data_lines_n_oe) |-> data_strobe_negative_n_out == 4'hf ##1
        data_strobe_negative_n_out == 4'hf ##1 data_strobe_negative_n_out == 4'hf ##1
        data_strobe_negative_n_out == 4'h0 ##1 data_strobe_negative_n_out == 4'h0 ##1
        data_strobe_negative_n_out == 4'hf ##2 data_strobe_negative_n_out == 4'h0)
        else $error("negative strobe pattern wrong");
    chk_word_pairs: assert property ($rose(data_lines_n_oe) |=> $stable(data_lines_n_out) ##2 $stable(data_lines_n_out))
        else $error("word changed mid pair");
    chk_idle_high: assert property (!data_lines_n_oe |-> &{data_lines_n_out, data_strobe_positive_n_out,
        data_strobe_negative_n_out, group_inversion_flag_n_out}) else $error("idle pins not high");
    chk_inv_low: assert property (data_lines_n_oe && !group_inversion_flag_n_out[0] |->
        $countones(data_lines_n_out[15:0]) > 8) else $error("group 0 inverted wrongly");
    chk_inv_high: assert property (data_lines_n_oe && group_inversion_flag_n_out[3] |->
        $countones(data_lines_n_out[63:48]) >= 8) else $error("group 3 not inverted");
    chk_rx_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("receive pulse too long");
    chk_busy_ready: assert property (data_lines_n_oe |-> !tx_ready)
        else $error("ready while driving");
    cover property ($rose(data_lines_n_oe));
    cover property (rx_valid);
    cover property (data_lines_n_oe && !group_inversion_flag_n_out[0]);
endmodule
bind quad_pumped_data_lanes lanes_monitor u_mon (.clk, .rst, .data_lines_n_out, .data_lines_n_oe,
    .data_strobe_positive_n_out, .data_strobe_positive_n_oe, .data_strobe_negative_n_out,
    .group_inversion_flag_n_out, .data_valid_indicator_n_out, .tx_ready, .rx_valid);
`default_nettype wire

// ==== sim/far_agent.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************
// Far bus agent
// ****************
module far_agent (
    // Clock and command
    input wire logic clk,
    input wire logic start,
    input wire lanes_pkg::burst_type burst,
    input wire logic [3:0] inv,
    input wire logic valid_on,
    // Pins, released high by termination
    output var lanes_pkg::pin_bundle_type pins
);
    initial begin
        pins = '1;
        forever begin
            @(posedge clk);
            if (start) begin
                for (int w = 0; w < 4; w++) begin
                    for (int g = 0; g < 4; g++) begin
                        pins.data[16*g +: 16] <= inv[g] ? burst.word[w][16*g +: 16] : ~burst.word[w][16*g +: 16];
                        pins.inv[g] <= !inv[g];
                    end
                    pins.valid <= !valid_on;
                    repeat (2) @(posedge clk);
                    // Alternate strobes so each falling edge is 4 clk apart
                    pins.strobe_p <= {4{w[0]}};
                    pins.strobe_n <= {4{!w[0]}};
                    repeat (2) @(posedge clk);
                end
                pins <= '1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/quad_pumped_data_lanes_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module quad_pumped_data_lanes_bench;
    localparam lanes_pkg::burst_type burst_a = {64'hffff_0000_00ff_01fe, 64'h0123_4567_89ab_cdef,
        64'h8001_fffe_0fff_7fff, 64'hffff_01ff_00ff_0000};
    localparam lanes_pkg::burst_type burst_b = {64'h0000_ffff_01ff_00ff, 64'hfedc_ba98_7654_3210,
        64'h7fff_0fff_fffe_8001, 64'h0000_00ff_01ff_ffff};
    logic clk = 1'b0, rst = 1'b1, bus_clk = 1'b0, tx_req = 1'b0, start = 1'b0, valid_on = 1'b0;
    logic [3:0] inv = 4'h0;
    lanes_pkg::burst_type tx_burst = '0, agent_burst = '0;
    lanes_pkg::pin_bundle_type ag;
    logic [63:0] d_out, rx_data;
    logic [3:0] sp_out, sn_out, f_out;
    logic oe, sp_oe, sn_oe, f_oe, v_out, v_oe, tx_ready, rx_valid;
    int num_errors = 0, checked = 0, cycles = 0;
    // Shared lines: released drivers leave the terminated level high
    wire logic [63:0] d_pin = (oe ? d_out : '1) & ag.data;
    wire logic [3:0] sp_pin = (sp_oe ? sp_out : '1) & ag.strobe_p;
    wire logic [3:0] sn_pin = (sn_oe ? sn_out : '1) & ag.strobe_n;
    wire logic [3:0] f_pin = (f_oe ? f_out : '1) & ag.inv;
    wire logic v_pin = (v_oe ? v_out : 1'b1) & ag.valid;
    initial forever #20 clk = ~clk;
    initial begin
        #7;
        forever #160 bus_clk = ~bus_clk;
    end
    quad_pumped_data_lanes u_dut (.clk, .rst, .bus_clk, .data_lines_n_in(d_pin), .data_lines_n_out(d_out),
        .data_lines_n_oe(oe), .data_strobe_positive_n_in(sp_pin), .data_strobe_positive_n_out(sp_out),
        .data_strobe_positive_n_oe(sp_oe), .data_strobe_negative_n_in(sn_pin), .data_strobe_negative_n_out(sn_out),
        .data_strobe_negative_n_oe(sn_oe), .group_inversion_flag_n_in(f_pin), .group_inversion_flag_n_out(f_out),
        .group_inversion_flag_n_oe(f_oe), .data_valid_indicator_n_in(v_pin), .data_valid_indicator_n_out(v_out),
        .data_valid_indicator_n_oe(v_oe), .tx_req, .tx_burst, .tx_ready, .rx_valid, .rx_data);
    far_agent u_agent (.clk, .start, .burst(agent_burst), .inv, .valid_on, .pins(ag));
    task automatic check(logic [67:0] seen, logic [67:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [67:0] enc(logic [63:0] w);
        for (int g = 0; g < 4; g++) begin
            enc[64+g] = $countones(w[16*g +: 16]) <= 8;
            enc[16*g +: 16] = enc[64+g] ? ~w[16*g +: 16] : w[16*g +: 16];
        end
    endfunction
    task automatic send(lanes_pkg::burst_type b);
        int k;
        logic [3:0] sp_exp, sn_exp;
        @(posedge clk);
        tx_req <= 1'b1;
        tx_burst <= b;
        @(posedge clk);
        tx_req <= 1'b0;
        k = 0;
        while (oe !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        for (int p = 0; p < 8; p++) begin
            check({f_out, d_out}, enc(b.word[p/2]));
            check({tx_ready, rx_valid}, 2'b00);
            sp_exp = (p % 4 == 1 || p % 4 == 2) ? 4'h0 : 4'hf;
            sn_exp = (p % 4 == 3 || p == 4) ? 4'h0 : 4'hf;
            check({v_out, sp_out, sn_out}, {1'b0, sp_exp, sn_exp});
            if (p % 4 == 0) check(bus_clk, p == 0);
            @(negedge clk);
        end
        check(oe, 1'b0);
    endtask
    task automatic recv(lanes_pkg::burst_type b, logic [3:0] iv, logic vo);
        int k;
        @(posedge clk);
        agent_burst <= b;
        inv <= iv;
        valid_on <= vo;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int w = 0; w < 4; w++) begin
            k = 0;
            while (rx_valid !== 1'b1 && k < 12) begin
                @(negedge clk);
                k++;
            end
            if (vo) check(rx_data, b.word[w]);
            else check(k, 12);
            @(negedge clk);
        end
    endtask
    task automatic print_verdict;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({oe, tx_ready, rx_valid, rx_data}, {3'b010, 64'h0});
        send(burst_a);
        send(burst_b);
        recv(burst_a, 4'b0101, 1'b1);
        recv(burst_b, 4'b1111, 1'b1);
        recv(burst_a, 4'b0000, 1'b0);
        print_verdict;
    end
endmodule
`default_nettype wire
